// ==== logic/rrc_defs.vh ====
// Register offsets, field positions and reset values of the radio control pages
// How it works
// - One shared attenuator bit lowers gain of the whole chain, both receivers.
// - Wait mode leaves the radio block running and its registers untouched.
// - Halt mode forces both receivers off and blocks every register write; bus reads still answer.
// - The block raises no interrupt requests at all.
// - Register space is paged; the page select register picks the controller shown.
// - Parameters are loaded into the signal processor when a receiver is enabled.
// - Each supply regulator has its own on/off bit.
// - Page select is read/write and resets to zero, page zero.
// - Two-bit page field picks status, common, receiver 0 or receiver 1 page.
// - Each receiver has an enable bit that starts and stops it.
`ifndef RRC_DEFS_VH
`define RRC_DEFS_VH
// Word offsets (byte address = 4 x index)
`define RRC_IDX_PAGE 4'h0
`define RRC_IDX_W1 4'h1
`define RRC_IDX_W2 4'h2
`define RRC_IDX_W3 4'h3
`define RRC_IDX_W4 4'h4
`define RRC_IDX_W5 4'h5
// Page numbers
`define RRC_PG_STATUS 2'h0
`define RRC_PG_COMMON 2'h1
`define RRC_PG_RX0 2'h2
`define RRC_PG_RX1 2'h3
// Fields
`define RRC_PAGE_LSB 0
`define RRC_TEST_BIT 6
`define RRC_ATN_BIT 0
`define RRC_INV_BIT 1
`define RRC_LOCK0_BIT 2
`define RRC_LOCK1_BIT 3
`define RRC_RXON_BIT 3
// Writable masks
`define RRC_PAGE_MASK 8'h43
`define RRC_CSR_MASK 8'h03
`define RRC_REG0_MASK 8'h1e
`define RRC_REG1_MASK 8'h1a
`define RRC_RXCSR_MASK 8'h9f
`define RRC_RST8 8'h00
`endif

// ==== logic/rrc_rx_ctrl.v ====
// One receiver controller page: control/status, parameters, load on enable
`timescale 1ns/1ps
module rrc_rx_ctrl (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register access
    input wire wr_i,
    input wire [3:0] idx_i,
    input wire [7:0] wdat_i,
    output reg [7:0] rdat_o,
    // Signal processor side
    output reg rx_on_o,
    output reg load_o,
    output reg [23:0] param_o
);
`include "rrc_defs.vh"
    reg [7:0] csr_r;
    reg [7:0] cfl_r;
    reg [7:0] cfh_r;
    reg [7:0] off_r;
    // Parameter writes; enable edge copies the set to the processor
    always @(posedge clk_i) begin
        if (rst_i) begin
            csr_r <= `RRC_RST8;
            cfl_r <= `RRC_RST8;
            cfh_r <= `RRC_RST8;
            off_r <= `RRC_RST8;
            rx_on_o <= 1'b0;
            load_o <= 1'b0;
            param_o <= 24'h000000;
        end else begin
            load_o <= 1'b0;
            if (wr_i) begin
                case (idx_i)
                    `RRC_IDX_W1: csr_r <= wdat_i & `RRC_RXCSR_MASK;
                    `RRC_IDX_W2: cfl_r <= wdat_i;
                    `RRC_IDX_W3: cfh_r <= wdat_i;
                    `RRC_IDX_W4: off_r <= wdat_i;
                    default: ;
                endcase
            end
            rx_on_o <= csr_r[`RRC_RXON_BIT];
            // Snapshot only on rising enable, so later edits wait for re-enable
            if (csr_r[`RRC_RXON_BIT] && !rx_on_o) begin
                load_o <= 1'b1;
                param_o <= {off_r, cfh_r, cfl_r};
            end
        end
    end
    // Readback
    always @* begin
        case (idx_i)
            `RRC_IDX_W1: rdat_o = csr_r;
            `RRC_IDX_W2: rdat_o = cfl_r;
            `RRC_IDX_W3: rdat_o = cfh_r;
            `RRC_IDX_W4: rdat_o = off_r;
            default: rdat_o = 8'h00;
        endcase
    end
endmodule

// ==== logic/rrc_top.v ====
// Paged radio control register bank with classic Wishbone slave
`timescale 1ns/1ps
module rrc_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Power mode and status from outside
    input wire halt_i,
    input wire lock0_i,
    input wire lock1_i,
    input wire [7:0] strength0_i,
    input wire [7:0] strength1_i,
    // Analog and processor controls
    output reg input_attenuator_enable_o,
    output reg iq_invert_o,
    output reg rx_test_o,
    output reg [7:0] synth_div_o,
    output reg [7:0] slicer_weight_o,
    output reg [3:0] regulator0_o,
    output reg [2:0] regulator1_o,
    output reg rx0_on_o,
    output reg rx1_on_o,
    output reg rx0_load_o,
    output reg rx1_load_o,
    output reg [23:0] rx0_param_o,
    output reg [23:0] rx1_param_o
);
`include "rrc_defs.vh"
    reg [7:0] radio_page_select_r;
    reg [7:0] csr_r;
    reg [7:0] synr_r;
    reg [7:0] reg0_r;
    reg [7:0] reg1_r;
    reg [7:0] tswr_r;
    reg [1:0] halt_s1_r;
    reg halt_r;
    reg [1:0] lk0_s_r;
    reg [1:0] lk1_s_r;
    reg [7:0] rd_nxt;
    wire [1:0] page_number_field;
    wire [3:0] idx;
    wire acc;
    wire wr;
    wire [7:0] rx0_rd;
    wire [7:0] rx1_rd;
    wire [3:0] rx1_idx;
    wire rx0_on;
    wire rx1_on;
    wire rx0_load;
    wire rx1_load;
    wire [23:0] rx0_par;
    wire [23:0] rx1_par;

    // Writes only land in low lane; halted block accepts none
    assign acc = cyc_i && stb_i && !ack_o;
    assign wr = acc && we_i && sel_i[0] && !halt_r;
    assign idx = adr_i[5:2];
    assign page_number_field = radio_page_select_r[1:0];
    // Page zero shows receiver 1's control word at index 2, so steer its readback there
    assign rx1_idx = (page_number_field == `RRC_PG_STATUS && idx == `RRC_IDX_W2) ?
        `RRC_IDX_W1 : idx;

    function [7:0] lock_bits;
        input l1;
        input l0;
        begin
            lock_bits = {4'h0, l1, l0, 2'b00};
        end
    endfunction

    // Halt and lock come from other domains: three flops for halt, two for each lock
    always @(posedge clk_i) begin
        if (rst_i) begin
            halt_s1_r <= 2'b00;
            lk0_s_r <= 2'b00;
            lk1_s_r <= 2'b00;
            halt_r <= 1'b0;
        end else begin
            halt_s1_r <= {halt_s1_r[0], halt_i};
            lk0_s_r <= {lk0_s_r[0], lock0_i};
            lk1_s_r <= {lk1_s_r[0], lock1_i};
            halt_r <= halt_s1_r[1]; // Wait mode has no input at all
        end
    end

    // Receiver controllers, written only on their own page; status page also reads their control words
    rrc_rx_ctrl u_rx0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr && page_number_field == `RRC_PG_RX0),
        .idx_i(idx),
        .wdat_i(dat_i[7:0]),
        .rdat_o(rx0_rd),
        .rx_on_o(rx0_on),
        .load_o(rx0_load),
        .param_o(rx0_par)
    );
    rrc_rx_ctrl u_rx1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr && page_number_field == `RRC_PG_RX1),
        .idx_i(rx1_idx),
        .wdat_i(dat_i[7:0]),
        .rdat_o(rx1_rd),
        .rx_on_o(rx1_on),
        .load_o(rx1_load),
        .param_o(rx1_par)
    );

    // Page select and common controller registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            radio_page_select_r <= `RRC_RST8;
            csr_r <= `RRC_RST8;
            synr_r <= `RRC_RST8;
            reg0_r <= `RRC_RST8;
            reg1_r <= `RRC_RST8;
            tswr_r <= `RRC_RST8;
        end else if (wr) begin
            if (idx == `RRC_IDX_PAGE) begin
                radio_page_select_r <= dat_i[7:0] & `RRC_PAGE_MASK;
            end else if (page_number_field == `RRC_PG_COMMON) begin
                case (idx)
                    `RRC_IDX_W1: csr_r <= dat_i[7:0] & `RRC_CSR_MASK;
                    `RRC_IDX_W2: synr_r <= dat_i[7:0];
                    `RRC_IDX_W3: reg0_r <= dat_i[7:0] & `RRC_REG0_MASK;
                    `RRC_IDX_W4: reg1_r <= dat_i[7:0] & `RRC_REG1_MASK;
                    `RRC_IDX_W5: tswr_r <= dat_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux for the selected page; index 0 reads page select on every page
    always @* begin
        rd_nxt = 8'h00;
        if (idx == `RRC_IDX_PAGE) begin
            rd_nxt = radio_page_select_r;
        end else begin
            case (page_number_field)
                `RRC_PG_STATUS: begin
                    case (idx)
                        `RRC_IDX_W1: rd_nxt = rx0_rd;
                        `RRC_IDX_W2: rd_nxt = rx1_rd;
                        `RRC_IDX_W3: rd_nxt = strength0_i;
                        `RRC_IDX_W4: rd_nxt = strength1_i;
                        default: rd_nxt = 8'h00;
                    endcase
                end
                `RRC_PG_COMMON: begin
                    case (idx)
                        `RRC_IDX_W1: rd_nxt = csr_r | lock_bits(lk1_s_r[1], lk0_s_r[1]);
                        `RRC_IDX_W2: rd_nxt = synr_r;
                        `RRC_IDX_W3: rd_nxt = reg0_r;
                        `RRC_IDX_W4: rd_nxt = reg1_r;
                        `RRC_IDX_W5: rd_nxt = tswr_r;
                        default: rd_nxt = 8'h00;
                    endcase
                end
                `RRC_PG_RX0: rd_nxt = rx0_rd;
                `RRC_PG_RX1: rd_nxt = rx1_rd;
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    // Bus answer one cycle after request; outputs are registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            input_attenuator_enable_o <= 1'b0;
            iq_invert_o <= 1'b0;
            rx_test_o <= 1'b0;
            synth_div_o <= 8'h00;
            slicer_weight_o <= 8'h00;
            regulator0_o <= 4'h0;
            regulator1_o <= 3'h0;
            rx0_on_o <= 1'b0;
            rx1_on_o <= 1'b0;
            rx0_load_o <= 1'b0;
            rx1_load_o <= 1'b0;
            rx0_param_o <= 24'h000000;
            rx1_param_o <= 24'h000000;
        end else begin
            ack_o <= acc;
            dat_o <= acc ? {24'h000000, rd_nxt} : 32'h00000000;
            input_attenuator_enable_o <= csr_r[`RRC_ATN_BIT];
            iq_invert_o <= csr_r[`RRC_INV_BIT];
            rx_test_o <= radio_page_select_r[`RRC_TEST_BIT];
            synth_div_o <= synr_r;
            slicer_weight_o <= tswr_r;
            regulator0_o <= reg0_r[4:1];
            regulator1_o <= {reg1_r[4], reg1_r[3], reg1_r[1]};
            // Halt forces the receivers inactive without touching registers
            rx0_on_o <= rx0_on && !halt_r;
            rx1_on_o <= rx1_on && !halt_r;
            rx0_load_o <= rx0_load;
            rx1_load_o <= rx1_load;
            rx0_param_o <= rx0_par;
            rx1_param_o <= rx1_par;
        end
    end
    // No interrupt output exists by design
endmodule

// ==== test/rrc_top_monitor.sv ====
// Port-level property checks for the paged radio control bank
`timescale 1ns/1ps
module rrc_top_monitor (
    // Clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Power mode and controls
    input wire halt_i,
    input wire input_attenuator_enable_o,
    input wire rx0_on_o,
    input wire rx0_load_o,
    input wire [23:0] rx0_param_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers: one ack a cycle after the take, never held, data zero between acks
    ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not idle");
    // Parameter capture only around the enable pulse
    load_pulse_a: assert property (rx0_load_o |=> !rx0_load_o) else $error("load held");
    load_on_a: assert property (rx0_load_o |-> rx0_on_o) else $error("load without run");
    param_hold_a: assert property ($changed(rx0_param_o) |-> ##[0:1] rx0_load_o)
        else $error("param moved");
    // Halt needs a few cycles to cross the synchroniser, so the antecedent is long
    halt_off_a: assert property (halt_i [*7] |-> !rx0_on_o) else $error("run in halt");
    halt_freeze_a: assert property (halt_i [*7] |=> $stable(input_attenuator_enable_o))
        else $error("halt write");
    cover property (cyc_i && stb_i && ack_o);
    cover property (rx0_load_o);
    cover property (halt_i [*7]);
endmodule

// ==== test/rrc_top_tb.sv ====
// Self-checking bench for the paged radio control bank
`timescale 1ns/1ps
module rrc_top_tb;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic halt_i = 0, lock0_i = 0, lock1_i = 0;
    logic [5:0] adr_i = 6'h0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, q, dat_o;
    logic [7:0] strength0_i = 8'h5c, strength1_i = 8'ha3, synth_div_o, slicer_weight_o;
    logic ack_o, input_attenuator_enable_o, iq_invert_o, rx_test_o, rx0_on_o, rx1_on_o;
    logic rx0_load_o, rx1_load_o;
    logic [3:0] regulator0_o;
    logic [2:0] regulator1_o;
    logic [23:0] rx0_param_o, rx1_param_o;
    integer fails = 0, cmp_count = 0, rx1_loads = 0;
    always #50 clk_i = ~clk_i;
    // Load strobe lasts one cycle, so it is counted rather than sampled once
    always @(posedge clk_i) if (rx1_load_o === 1'b1) rx1_loads <= rx1_loads + 1;
    rrc_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .halt_i, .lock0_i, .lock1_i, .strength0_i, .strength1_i, .input_attenuator_enable_o,
        .iq_invert_o, .rx_test_o, .synth_div_o, .slicer_weight_o, .regulator0_o,
        .regulator1_o, .rx0_on_o, .rx1_on_o, .rx0_load_o, .rx1_load_o, .rx0_param_o,
        .rx1_param_o);
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    // One classic cycle; the wait for ack is bounded so a dead slave ends the run
    task wb(input logic w, input logic [3:0] i, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {i, 2'h0};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        if (n >= 20) begin
            fails++;
            summarize;
        end
    endtask
    task wr(input logic [3:0] i, input logic [7:0] d);
        wb(1, i, d);
    endtask
    task rd(input string n, input logic [3:0] i, input logic [7:0] e);
        wb(0, i, 8'h0);
        chk(n, q, {24'h0, e});
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk_i);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        rd("page reset", 0, 8'h00);
        wr(0, 8'hff);
        rd("page mask", 0, 8'h43);
        chk("test out", rx_test_o, 1);
        // Every page number reads back as written
        for (int p = 0; p < 4; p++) begin
            wr(0, p[7:0]);
            rd("page sel", 0, p[7:0]);
        end
        // Common page: attenuator, lock status, regulators
        wr(0, 8'h01);
        lock0_i <= 1;
        wr(1, 8'hff);
        wr(2, 8'h96);
        wr(3, 8'hff);
        wr(4, 8'hff);
        wr(5, 8'h22);
        rd("common csr", 1, 8'h07);
        chk("atten", input_attenuator_enable_o, 1);
        chk("invert", iq_invert_o, 1);
        rd("reg0", 3, 8'h1e);
        chk("reg0 out", regulator0_o, 4'hf);
        rd("reg1", 4, 8'h1a);
        chk("reg1 out", regulator1_o, 3'h7);
        wr(3, 8'h04);
        tick(1);
        chk("reg0 one", regulator0_o, 4'h2);
        sel_i <= 4'he;
        wr(5, 8'h99);
        sel_i <= 4'hf;
        tick(1);
        chk("no lane", slicer_weight_o, 8'h22);
        // Receiver pages must not disturb each other or the common page
        wr(0, 8'h02);
        wr(2, 8'h5a);
        wr(3, 8'ha5);
        wr(4, 8'h3c);
        wr(0, 8'h03);
        wr(2, 8'h11);
        rd("unmapped", 5, 8'h00);
        wr(0, 8'h02);
        rd("rx0 cf", 2, 8'h5a);
        chk("synth", synth_div_o, 8'h96);
        wr(1, 8'h08);
        tick(3);
        chk("rx0 on", rx0_on_o, 1);
        chk("rx0 par", rx0_param_o, 24'h3ca55a);
        wr(2, 8'h77);
        chk("par hold", rx0_param_o, 24'h3ca55a);
        wr(1, 8'h00);
        wr(1, 8'h08);
        tick(3);
        chk("par load", rx0_param_o, 24'h3ca577);
        chk("rx1 off", rx1_on_o, 0);
        wr(0, 8'h00);
        rd("rx0 csr", 1, 8'h08);
        rd("rx1 csr", 2, 8'h00);
        rd("strength", 3, 8'h5c);
        // Halt blocks writes; receivers are stopped first as software must
        wr(0, 8'h02);
        wr(1, 8'h00);
        halt_i <= 1;
        tick(8);
        chk("halt rx", rx0_on_o, 0);
        wr(0, 8'h01);
        rd("frozen", 0, 8'h02);
        wr(1, 8'h08);
        rd("frozen csr", 1, 8'h00);
        halt_i <= 0;
        tick(8);
        // Clock source choice lives outside this block; the bench only waits here
        wr(1, 8'h08);
        tick(3);
        chk("resume", rx0_on_o, 1);
        chk("resume par", rx0_param_o, 24'h3ca577);
        // Receiver 1 page: its own load pulse and parameter set
        wr(0, 8'h03);
        wr(1, 8'h08);
        tick(3);
        chk("rx1 on", rx1_on_o, 1);
        chk("rx1 par", rx1_param_o, 24'h000011);
        chk("rx1 load", rx1_loads, 1);
        summarize;
    end
endmodule
bind rrc_top rrc_top_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .halt_i,
    .input_attenuator_enable_o, .rx0_on_o, .rx0_load_o, .rx0_param_o);
